//--- hdl/eps_pkg.sv
package eps_pkg;

   // =========================================================
   // Geometry
   // =========================================================
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   localparam int ID_SEL_BIT = 9;
   localparam int ID_BYTE_BIT = 0;

   // =========================================================
   // Timing
   // =========================================================
   localparam int CLK_MHZ = 50;
   localparam int LONG_PULSE_US = 1000;
   localparam int LONG_PULSE_CYC = LONG_PULSE_US * CLK_MHZ;
   localparam int SHORT_PULSE_US = 100;
   localparam int SHORT_PULSE_CYC = SHORT_PULSE_US * CLK_MHZ;
   localparam int OVER_MULT = 3;
   localparam int SETUP_US = 2;
   localparam int SETUP_CYC = SETUP_US * CLK_MHZ;
   localparam int OUT_VALID_NS = 150;
   localparam int OUT_VALID_CYC = (OUT_VALID_NS * CLK_MHZ + 999) / 1000 + 2;
   localparam int MAX_PULSES = 25;
   localparam int CNT_W = 32;

   // =========================================================
   // Supply selections
   // =========================================================
   typedef enum logic [1:0] {EPS_SUP_OFF, EPS_SUP_READ, EPS_SUP_LONG, EPS_SUP_SHORT} eps_supply_t;

   // =========================================================
   // Carriers
   // =========================================================
   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic program_strobe_low;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dout;
      logic dout_oe;
      logic id_hv;
      logic vcc_on;
      logic vpp_on;
      eps_supply_t level;
   } eps_pins_t;

   typedef struct packed {
      logic busy;
      logic done;
      logic fail;
      logic long_method;
      logic [DATA_W-1:0] maker_code;
      logic [DATA_W-1:0] type_code;
      logic [ADDR_W-1:0] fail_addr;
   } eps_status_t;

endpackage

//--- hdl/eps_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module eps_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW:0] wr_q;
   logic [PW:0] rd_q;
   logic push;
   logic pop;

   assign in_ready_o = (wr_q - rd_q) != (PW+1)'(DEPTH);
   assign out_valid_o = wr_q != rd_q;
   assign out_data_o = mem_q[rd_q[PW-1:0]];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem_q[wr_q[PW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         wr_q <= '0;
         rd_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop)
         begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

//--- hdl/eps_sync.sv
`timescale 1ns/1ps
`default_nettype none
module eps_sync #(
   parameter int WIDTH = 8
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   assign q_o = sync_q;

   // Two stages: pin data changes without regard to our clock.
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         meta_q <= '1;
         sync_q <= '1;
      end
      else
      begin
         meta_q <= d_i;
         sync_q <= meta_q;
      end
   end
endmodule
`default_nettype wire

//--- hdl/eps_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1: long method: 1 ms pulses, max 25
// RULE2: then overprogram pulse of 3X ms
// RULE3: overprogram width within 2.85 to 78.75 ms
// RULE4: long method supplies 6.0 V and 12.5 V
// RULE5: long method: final compare at 5.0 V
// RULE6: chip select high inhibits programming
// RULE7: low strobe with chip select programs byte
// RULE8: verify with gates low, wait 150 ns
// RULE9: high voltage on identifier select enters identifier
// RULE10: byte select picks maker or type code
// RULE11: other address lines low in identifier mode
// RULE12: read identifier first, pick method from it
// RULE13: short method: 100 us pulses until verified
// RULE14: short method: fail after 25 pulses
// RULE15: short method supplies 6.25 V and 12.75 V
// RULE16: short method final compare at 5.0 V
// RULE17: core supply up first, down last
// RULE18: data byte driven in parallel when programming
// RULE19: erased reads ones; only zeros programmable
// RULE20: addresses in order, byte finished before next
// RULE21: fail on compare mismatch or budget exhausted
module eps_sequencer
   import eps_pkg::*;
#(
   parameter int DEPTH = 32,
   parameter int LONG_PULSE_CYCLES = eps_pkg::LONG_PULSE_CYC,
   parameter int SHORT_PULSE_CYCLES = eps_pkg::SHORT_PULSE_CYC,
   parameter int SETUP_CYCLES = eps_pkg::SETUP_CYC,
   parameter logic [7:0] LONG_TYPE_CODE = 8'hA5, // Arbitrary value.
   parameter logic [eps_pkg::ADDR_W-1:0] LAST_ADDR = 13'h1FFF
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // User commands
   input wire logic start_i,
   input wire logic [eps_pkg::ADDR_W-1:0] start_addr_i,
   input wire logic [eps_pkg::ADDR_W-1:0] end_addr_i,
   // Source data stream, one byte per address in order
   input wire logic src_valid_i,
   output logic src_ready_o,
   input wire logic [eps_pkg::DATA_W-1:0] src_data_i,
   // Compare data stream, same bytes again for the final pass
   input wire logic cmp_valid_i,
   output logic cmp_ready_o,
   input wire logic [eps_pkg::DATA_W-1:0] cmp_data_i,
   // Device pins
   output eps_pkg::eps_pins_t pins_o,
   input wire logic [eps_pkg::DATA_W-1:0] dev_data_i,
   // Status
   output eps_pkg::eps_status_t status_o
);
   import eps_pkg::*;

   // =========================================================
   // State
   // =========================================================
   typedef enum {
      ST_IDLE, ST_PWR_VCC, ST_PWR_VPP, ST_ID_SETUP, ST_ID_READ, ST_ID_NEXT,
      ST_PROG_SUP, ST_FETCH, ST_SETUP, ST_PULSE, ST_GAP, ST_VERIFY, ST_OVER,
      ST_CMP_SUP, ST_CMP_RD, ST_PWR_DN_VPP, ST_PWR_DN_VCC
   } eps_state_t;

   eps_state_t state_q;
   eps_pins_t pins_q;
   eps_status_t stat_q;
   logic [CNT_W-1:0] tmr_q;
   logic [5:0] iter_q;
   logic [ADDR_W-1:0] addr_q;
   logic [ADDR_W-1:0] last_q;
   logic [DATA_W-1:0] byte_q;
   logic id_byte_q;
   logic fail_q;
   logic fifo_valid;
   logic fifo_pop;
   logic [DATA_W-1:0] fifo_data;
   logic [DATA_W-1:0] rd_data;
   logic cmp_take;

   assign pins_o = pins_q;
   assign status_o = stat_q;

   // =========================================================
   // Source buffer and read-back synchroniser
   // =========================================================
   eps_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_fifo (
      .clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .in_valid_i(src_valid_i),
      .in_ready_o(src_ready_o),
      .in_data_i(src_data_i),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_pop),
      .out_data_o(fifo_data)
   );

   eps_sync #(.WIDTH(DATA_W)) u_sync (
      .clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .d_i(dev_data_i),
      .q_o(rd_data)
   );

   assign fifo_pop = (state_q == ST_FETCH) && fifo_valid;
   assign cmp_take = (state_q == ST_CMP_RD) && (tmr_q == '0) && cmp_valid_i;
   assign cmp_ready_o = cmp_take;

   // =========================================================
   // Sequencer
   // =========================================================
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state_q <= ST_IDLE;
         tmr_q <= '0;
         iter_q <= '0;
         addr_q <= '0;
         last_q <= '0;
         byte_q <= 8'hFF;
         id_byte_q <= 1'b0;
         fail_q <= 1'b0;
      end
      else
      begin
         if (tmr_q != '0)
         begin
            tmr_q <= tmr_q - 1'b1;
         end
         case (state_q)
            ST_IDLE:
            begin
               if (start_i)
               begin
                  addr_q <= start_addr_i;
                  last_q <= (end_addr_i > LAST_ADDR) ? LAST_ADDR : end_addr_i;
                  fail_q <= 1'b0;
                  id_byte_q <= 1'b0;
                  tmr_q <= CNT_W'(SETUP_CYCLES);
                  state_q <= ST_PWR_VCC;
               end
            end
            ST_PWR_VCC:
            begin
               // Core supply settles before the programming supply is raised.
               if (tmr_q == '0)
               begin
                  tmr_q <= CNT_W'(SETUP_CYCLES);
                  state_q <= ST_PWR_VPP; // see RULE17
               end
            end
            ST_PWR_VPP:
            begin
               if (tmr_q == '0)
               begin
                  tmr_q <= CNT_W'(SETUP_CYCLES);
                  state_q <= ST_ID_SETUP;
               end
            end
            ST_ID_SETUP:
            begin
               if (tmr_q == '0)
               begin
                  tmr_q <= CNT_W'(OUT_VALID_CYC);
                  state_q <= ST_ID_READ;
               end
            end
            ST_ID_READ:
            begin
               if (tmr_q == '0)
               begin
                  if (!id_byte_q)
                  begin
                     id_byte_q <= 1'b1;
                     tmr_q <= CNT_W'(SETUP_CYCLES);
                     state_q <= ST_ID_SETUP; // see RULE10
                  end
                  else
                  begin
                     tmr_q <= CNT_W'(SETUP_CYCLES);
                     state_q <= ST_PROG_SUP;
                  end
               end
            end
            ST_PROG_SUP:
            begin
               if (tmr_q == '0)
               begin
                  state_q <= ST_FETCH;
               end
            end
            ST_FETCH:
            begin
               if (fifo_valid)
               begin
                  byte_q <= fifo_data;
                  iter_q <= '0;
                  tmr_q <= CNT_W'(SETUP_CYCLES);
                  state_q <= ST_SETUP;
               end
            end
            ST_SETUP:
            begin
               if (tmr_q == '0)
               begin
                  // An all-ones byte needs no pulses: erased cells already read as ones.
                  if (byte_q == 8'hFF)
                  begin
                     state_q <= ST_GAP; // see RULE19
                  end
                  else
                  begin
                     // The timer state lasts one cycle past its load, so a width of N cycles loads N-1.
                     tmr_q <= stat_q.long_method ? CNT_W'(LONG_PULSE_CYCLES - 1) : CNT_W'(SHORT_PULSE_CYCLES - 1);
                     iter_q <= iter_q + 6'd1;
                     state_q <= ST_PULSE; // see RULE1
                  end
               end
            end
            ST_PULSE:
            begin
               if (tmr_q == '0)
               begin
                  tmr_q <= CNT_W'(SETUP_CYCLES);
                  state_q <= ST_GAP;
               end
            end
            ST_GAP:
            begin
               if (tmr_q == '0)
               begin
                  tmr_q <= CNT_W'(OUT_VALID_CYC);
                  state_q <= ST_VERIFY;
               end
            end
            ST_VERIFY:
            begin
               // Read-back is sampled only after the output-valid delay plus sync latency.
               if (tmr_q == '0)
               begin
                  if (rd_data == byte_q)
                  begin
                     if (stat_q.long_method && iter_q != '0)
                     begin
                        tmr_q <= CNT_W'(LONG_PULSE_CYCLES) * CNT_W'(OVER_MULT) * CNT_W'(iter_q) - 1'b1;
                        state_q <= ST_OVER; // see RULE2, RULE3
                     end
                     else if (addr_q == last_q)
                     begin
                        tmr_q <= CNT_W'(SETUP_CYCLES);
                        state_q <= ST_CMP_SUP;
                     end
                     else
                     begin
                        addr_q <= addr_q + 1'b1;
                        state_q <= ST_FETCH; // see RULE20
                     end
                  end
                  else if (iter_q >= 6'(MAX_PULSES))
                  begin
                     fail_q <= 1'b1;
                     tmr_q <= CNT_W'(SETUP_CYCLES);
                     state_q <= ST_PWR_DN_VPP; // see RULE14, RULE21
                  end
                  else
                  begin
                     tmr_q <= stat_q.long_method ? CNT_W'(LONG_PULSE_CYCLES - 1) : CNT_W'(SHORT_PULSE_CYCLES - 1);
                     iter_q <= iter_q + 6'd1;
                     state_q <= ST_PULSE; // see RULE13
                  end
               end
            end
            ST_OVER:
            begin
               if (tmr_q == '0)
               begin
                  iter_q <= '0;
                  tmr_q <= CNT_W'(SETUP_CYCLES);
                  if (addr_q == last_q)
                  begin
                     state_q <= ST_CMP_SUP;
                  end
                  else
                  begin
                     addr_q <= addr_q + 1'b1;
                     state_q <= ST_FETCH; // see RULE20
                  end
               end
            end
            ST_CMP_SUP:
            begin
               if (tmr_q == '0)
               begin
                  addr_q <= start_addr_i;
                  tmr_q <= CNT_W'(SETUP_CYCLES);
                  state_q <= ST_CMP_RD;
               end
            end
            ST_CMP_RD:
            begin
               if (cmp_take)
               begin
                  if (rd_data != cmp_data_i)
                  begin
                     fail_q <= 1'b1; // see RULE21
                  end
                  tmr_q <= CNT_W'(SETUP_CYCLES);
                  if (addr_q == last_q)
                  begin
                     state_q <= ST_PWR_DN_VPP;
                  end
                  else
                  begin
                     addr_q <= addr_q + 1'b1;
                  end
               end
            end
            ST_PWR_DN_VPP:
            begin
               if (tmr_q == '0)
               begin
                  tmr_q <= CNT_W'(SETUP_CYCLES);
                  state_q <= ST_PWR_DN_VCC; // see RULE17
               end
            end
            ST_PWR_DN_VCC:
            begin
               if (tmr_q == '0)
               begin
                  state_q <= ST_IDLE;
               end
            end
            default:
            begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // =========================================================
   // Pin drive, registered so outputs come from flip-flops
   // =========================================================
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         pins_q <= '{ce_n: 1'b1, oe_n: 1'b1, program_strobe_low: 1'b1, addr: '0, dout: '0,
                     dout_oe: 1'b0, id_hv: 1'b0, vcc_on: 1'b0, vpp_on: 1'b0, level: EPS_SUP_OFF};
      end
      else
      begin
         pins_q.ce_n <= !(state_q inside {ST_ID_SETUP, ST_ID_READ, ST_SETUP, ST_PULSE, ST_GAP,
                                           ST_VERIFY, ST_OVER, ST_CMP_RD}); // see RULE6
         pins_q.oe_n <= !(state_q inside {ST_ID_READ, ST_VERIFY, ST_CMP_RD}); // see RULE8
         pins_q.program_strobe_low <= !(state_q inside {ST_PULSE, ST_OVER}); // see RULE7
         pins_q.dout <= byte_q;
         pins_q.dout_oe <= state_q inside {ST_SETUP, ST_PULSE, ST_GAP, ST_OVER}; // see RULE18
         if (state_q inside {ST_ID_SETUP, ST_ID_READ})
         begin
            pins_q.addr <= '0;
            pins_q.addr[ID_SEL_BIT] <= 1'b1;
            pins_q.addr[ID_BYTE_BIT] <= id_byte_q; // see RULE11
            pins_q.id_hv <= 1'b1; // see RULE9
         end
         else
         begin
            pins_q.addr <= addr_q;
            pins_q.id_hv <= 1'b0;
         end
         pins_q.vcc_on <= !(state_q inside {ST_IDLE});
         pins_q.vpp_on <= !(state_q inside {ST_IDLE, ST_PWR_VCC, ST_PWR_DN_VCC, ST_CMP_SUP, ST_CMP_RD,
                                            ST_PWR_DN_VPP, ST_ID_SETUP, ST_ID_READ}); // see RULE17, RULE16
         if (state_q inside {ST_PROG_SUP, ST_FETCH, ST_SETUP, ST_PULSE, ST_GAP, ST_VERIFY, ST_OVER})
         begin
            pins_q.level <= stat_q.long_method ? EPS_SUP_LONG : EPS_SUP_SHORT; // see RULE4, RULE15
         end
         else if (state_q == ST_IDLE)
         begin
            pins_q.level <= EPS_SUP_OFF;
         end
         else
         begin
            pins_q.level <= EPS_SUP_READ; // see RULE5
         end
      end
   end

   // =========================================================
   // Status
   // =========================================================
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         stat_q <= '0;
      end
      else
      begin
         stat_q.busy <= state_q != ST_IDLE;
         stat_q.fail <= fail_q;
         stat_q.fail_addr <= addr_q;
         if (state_q == ST_IDLE && start_i)
         begin
            stat_q.done <= 1'b0;
         end
         else if (state_q == ST_PWR_DN_VCC && tmr_q == '0)
         begin
            stat_q.done <= 1'b1;
         end
         if (state_q == ST_ID_READ && tmr_q == '0)
         begin
            if (!id_byte_q)
            begin
               stat_q.maker_code <= rd_data;
            end
            else
            begin
               stat_q.type_code <= rd_data;
               stat_q.long_method <= rd_data == LONG_TYPE_CODE; // see RULE12
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- sim/eps_seq_properties.sv
`timescale 1ns/1ps
`default_nettype none
module eps_seq_properties #(
   parameter int LONG_PULSE_CYCLES = 20,
   parameter int SHORT_PULSE_CYCLES = 5
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // Watched ports
   input wire logic start_i,
   input wire logic cmp_ready_o,
   input wire eps_pkg::eps_pins_t pins_o,
   input wire eps_pkg::eps_status_t status_o
);
   import eps_pkg::*;
   logic strobe;
   logic prev_q;
   logic [31:0] wcnt_q;
   logic [7:0] pcnt_q;
   logic [12:0] paddr_q;
   assign strobe = pins_o.program_strobe_low;
   // A pulse is one initial width or an overprogram of 3 to 75 long widths.
   function automatic logic width_ok(logic [31:0] w);
      width_ok = (w == SHORT_PULSE_CYCLES) || (w == LONG_PULSE_CYCLES);
      for (int k = 1; k <= 25; k++)
         if (w == 3 * k * LONG_PULSE_CYCLES) width_ok = 1'b1;
   endfunction
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
      if (!rst_b_i) wcnt_q <= 32'h0;
      else wcnt_q <= strobe ? 32'h0 : wcnt_q + 32'h1;
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
      if (!rst_b_i) prev_q <= 1'b1;
      else prev_q <= strobe;
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
      if (!rst_b_i) paddr_q <= 13'h0;
      else paddr_q <= pins_o.addr;
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
      if (!rst_b_i) pcnt_q <= 8'h0;
      else if (pins_o.addr != paddr_q) pcnt_q <= 8'h0;
      else if (prev_q && !strobe) pcnt_q <= pcnt_q + 8'h1;
   // =========================================================
   // Properties
   // =========================================================
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   a_pulse_select: assert property (!strobe |-> !pins_o.ce_n && pins_o.vpp_on)
      else $error("strobe low while unselected or vpp off");
   a_pulse_data: assert property (!strobe |-> pins_o.dout_oe)
      else $error("strobe low without data driven");
   a_supply_order: assert property (pins_o.vpp_on |-> pins_o.vcc_on)
      else $error("vpp on without vcc");
   a_verify_gate: assert property (!pins_o.oe_n |-> !pins_o.dout_oe && strobe)
      else $error("output gate low while driving or pulsing");
   a_id_lines: assert property (pins_o.id_hv |-> (pins_o.addr & 13'h1DFE) == 13'h0000)
      else $error("address lines not low in identifier mode");
   a_pulse_width: assert property ($rose(strobe) |-> width_ok(wcnt_q))
      else $error("strobe pulse width wrong");
   a_pulse_budget: assert property (pcnt_q <= 8'd26)
      else $error("too many pulses on one byte");
   a_method_level: assert property (!strobe |->
      pins_o.level == (status_o.long_method ? EPS_SUP_LONG : EPS_SUP_SHORT))
      else $error("supply level wrong for method");
   a_compare_read: assert property (cmp_ready_o |-> pins_o.level == EPS_SUP_READ && !pins_o.vpp_on)
      else $error("final compare not at read level");
   a_start_busy: assert property (start_i && !status_o.busy |-> ##2 status_o.busy)
      else $error("busy did not follow start");
   c_fail: cover property ($rose(status_o.done) && status_o.fail);
   c_long: cover property ($rose(status_o.done) && status_o.long_method);
   c_type_read: cover property (pins_o.id_hv && pins_o.addr[0]);
endmodule
bind eps_sequencer eps_seq_properties #(
   .LONG_PULSE_CYCLES(LONG_PULSE_CYCLES),
   .SHORT_PULSE_CYCLES(SHORT_PULSE_CYCLES)
) eps_seq_properties_inst (
   .sys_clk_i(sys_clk_i),
   .rst_b_i(rst_b_i),
   .start_i(start_i),
   .cmp_ready_o(cmp_ready_o),
   .pins_o(pins_o),
   .status_o(status_o)
);
`default_nettype wire

//--- sim/eps_eprom_model.sv
`timescale 1ns/1ps
`default_nettype none
module eps_eprom_model #(
   parameter logic [7:0] MAKER_CODE = 8'h3C, // Arbitrary value.
   parameter int NEED_PULSES = 2
) (
   // Pins from the controller
   input wire eps_pkg::eps_pins_t pins_i,
   input wire logic [7:0] type_code_i,
   input wire logic [12:0] stuck_addr_i,
   // Data back to the controller
   output logic [7:0] dev_data_o
);
   import eps_pkg::*;
   logic [7:0] mem [0:8191];
   logic [7:0] rd;
   logic [7:0] last;
   logic drive;
   int cnt;
   logic [12:0] caddr;
   initial
   begin
      for (int i = 0; i < 8192; i++) mem[i] = 8'hFF;
      last = 8'h00;
      cnt = 0;
      caddr = 13'h0;
   end
   // A byte takes NEED_PULSES pulses; the stuck address takes pulses but its cell never changes.
   always @(posedge pins_i.program_strobe_low)
      if (!pins_i.ce_n && pins_i.vpp_on && pins_i.dout_oe && pins_i.level inside {EPS_SUP_LONG, EPS_SUP_SHORT})
      begin
         if (pins_i.addr != caddr) cnt = 0;
         caddr = pins_i.addr;
         cnt++;
         if (cnt >= NEED_PULSES && pins_i.addr != stuck_addr_i)
            mem[pins_i.addr] = mem[pins_i.addr] & pins_i.dout;
      end
   assign drive = !pins_i.ce_n && !pins_i.oe_n && !pins_i.dout_oe;
   assign rd = pins_i.id_hv ? (pins_i.addr[0] ? type_code_i : MAKER_CODE) : mem[pins_i.addr];
   always @*
      if (drive) last = rd;
   // Released pins show the inverse so a stale read cannot pass.
   assign dev_data_o = drive ? rd : ~last;
endmodule
`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import eps_pkg::*;
   localparam logic [7:0] MAKER = 8'h3C; // Arbitrary value.
   localparam logic [7:0] LONG_CODE = 8'hA5; // Arbitrary value.
   logic sys_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic start_i = 1'b0;
   logic [12:0] start_addr_i = 13'h0;
   logic [12:0] end_addr_i = 13'h0;
   logic src_valid_i = 1'b0;
   logic [7:0] src_data_i = 8'h00;
   logic cmp_valid_i = 1'b0;
   logic [7:0] cmp_data_i = 8'h00;
   logic src_ready_o;
   logic cmp_ready_o;
   eps_pins_t pins_o;
   eps_status_t status_o;
   logic [7:0] dev_data_i;
   logic [7:0] type_code = 8'h5A;
   logic [12:0] stuck = 13'h0FFF;
   int errors = 0;
   int cmp_count = 0;
   logic [7:0] srcq[$];
   logic [7:0] cmpq[$];
   logic [7:0] data [0:63];
   always #10 sys_clk_i = ~sys_clk_i;
   eps_sequencer #(.LONG_PULSE_CYCLES(20), .SHORT_PULSE_CYCLES(5), .SETUP_CYCLES(3),
      .LONG_TYPE_CODE(LONG_CODE)) eps_sequencer_inst (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
      .start_i(start_i), .start_addr_i(start_addr_i), .end_addr_i(end_addr_i),
      .src_valid_i(src_valid_i), .src_ready_o(src_ready_o), .src_data_i(src_data_i),
      .cmp_valid_i(cmp_valid_i), .cmp_ready_o(cmp_ready_o), .cmp_data_i(cmp_data_i),
      .pins_o(pins_o), .dev_data_i(dev_data_i), .status_o(status_o));
   eps_eprom_model #(.MAKER_CODE(MAKER)) eps_eprom_model_inst (.pins_i(pins_o),
      .type_code_i(type_code), .stuck_addr_i(stuck), .dev_data_o(dev_data_i));
   // =========================================================
   // Stream feeders
   // =========================================================
   always @(posedge sys_clk_i)
   begin
      if (src_valid_i && src_ready_o === 1'b1) void'(srcq.pop_front());
      if (cmp_valid_i && cmp_ready_o === 1'b1) void'(cmpq.pop_front());
      #1;
      src_valid_i = srcq.size() > 0;
      src_data_i = src_valid_i ? srcq[0] : 8'h00;
      cmp_valid_i = cmpq.size() > 0;
      cmp_data_i = cmp_valid_i ? cmpq[0] : 8'h00;
   end
   task automatic tick();
      @(posedge sys_clk_i);
      #1;
   endtask
   task automatic chk_flag(input logic got, input logic exp, input string what);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: %s got %b", $time, what, got);
      end
   endtask
   task automatic chk_val(input logic [12:0] got, input logic [12:0] exp, input string what);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   // The stuck cell takes pulses but stays erased.
   function automatic logic [7:0] exp_cell(input logic [12:0] a, input logic [12:0] stk, input logic [7:0] d);
      exp_cell = (a == stk) ? 8'hFF : d;
   endfunction
   task automatic summarize();
      $display("comparisons %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic run_job(input logic [12:0] first, input int n, input logic [7:0] code, input int bad,
      input logic [12:0] stk, input logic exp_fail);
      logic [12:0] a;
      int k;
      type_code = code;
      stuck = stk;
      for (k = 0; k < n; k++)
      begin
         data[k] = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom()) & 8'h7F;
         srcq.push_back(data[k]);
         cmpq.push_back(k == bad ? ~data[k] : data[k]);
      end
      repeat (40) tick();
      if (n > 32) chk_flag(src_ready_o, 1'b0, "fifo full");
      start_addr_i = first;
      end_addr_i = 13'(first + n - 1);
      start_i = 1'b1;
      tick();
      start_i = 1'b0;
      tick();
      tick();
      chk_flag(status_o.busy, 1'b1, "busy");
      start_i = 1'b1;
      tick();
      start_i = 1'b0;
      k = 0;
      while (status_o.done !== 1'b1 && k < 30000)
      begin
         tick();
         k++;
      end
      if (k >= 30000)
      begin
         errors++;
         $display("mismatch at %0t: done timeout", $time);
         summarize();
      end
      chk_flag(status_o.fail, exp_fail, "fail");
      chk_flag(status_o.long_method, code == LONG_CODE, "method");
      chk_val(13'(status_o.maker_code), 13'(MAKER), "maker");
      chk_val(13'(status_o.type_code), 13'(code), "type");
      for (k = 0; k < n; k++)
      begin
         a = 13'(first + k);
         chk_val(13'(eps_eprom_model_inst.mem[a]), 13'(exp_cell(a, stk, data[k])), "cell");
      end
      if (exp_fail && bad < 0) chk_val(status_o.fail_addr, stk, "fail addr");
      srcq.delete();
      cmpq.delete();
      tick();
   endtask
   initial
   begin
      void'($urandom(32'hDCCE));
      repeat (12) @(posedge sys_clk_i);
      #1;
      rst_b_i = 1'b1;
      run_job(13'($urandom() % 256), 33, 8'h5A, -1, 13'h0FFF, 1'b0);
      run_job(13'h1000, 4, LONG_CODE, -1, 13'h0FFF, 1'b0);
      run_job(13'h1800, 3, 8'h5A, -1, 13'h1802, 1'b1);
      run_job(13'h1FFE, 2, LONG_CODE, 1, 13'h0FFF, 1'b1);
      summarize();
   end
endmodule
`default_nettype wire
